//--- ecc_engine.sv
// external memory correction engine with its apb register file
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns
module ecc_engine
	import ecc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// cpu bus unit side
	input wire logic ext_wr,
	input wire logic ext_rd,
	input wire logic [data_w-1:0] cpu_wdata,
	output logic [data_w-1:0] cpu_rdata,
	output logic cpu_rvalid,
	// memory side
	input wire logic [data_w-1:0] mem_rdata,
	output logic [data_w-1:0] mem_wdata,
	input wire logic [chk_w-1:0] check_in,
	output logic [chk_w-1:0] check_out,
	output logic check_oe,
	input wire logic correction_enable_input,
	output logic irq
);
	logic en_s1_q;
	logic en_s2_q;
	logic [chk_w-1:0] chk_s1_q;
	logic [chk_w-1:0] chk_s2_q;
	logic [data_w-1:0] md_s1_q;
	logic [data_w-1:0] md_s2_q;
	logic [7:0] ccs_q;
	logic [ev_w-1:0] status_q;
	logic [ev_w-1:0] enable_q;
	logic sgl_ev;
	logic dbl_ev;
	logic prot_rd;
	logic wr_acc;
	logic rd_acc;
	logic [ev_w-1:0] clr;
	logic [ev_w-1:0] ev;
	logic [ev_w-1:0] gate;
	logic [1:0] mode;

	ecc_if e();

	ecc_codec u_codec
	(
		.c(e)
	);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// enable level is held stable by the system for the access
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			en_s1_q <= 1'b0;
			en_s2_q <= 1'b0;
		end
		else
		begin
			en_s1_q <= correction_enable_input;
			en_s2_q <= en_s1_q;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			chk_s1_q <= '0;
			chk_s2_q <= '0;
			md_s1_q <= '0;
			md_s2_q <= '0;
		end
		else
		begin
			chk_s1_q <= check_in;
			chk_s2_q <= chk_s1_q;
			md_s1_q <= mem_rdata;
			md_s2_q <= md_s1_q;
		end
	end

	// ------------------------------------------------------------
	// datapath
	// ------------------------------------------------------------
	assign e.wdata = cpu_wdata;
	assign e.rdata = md_s2_q;
	assign e.rcheck = chk_s2_q;
	assign prot_rd = ext_rd && en_s2_q;

	// write data and check bits are registered together
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			mem_wdata <= '0;
			check_out <= '0;
			check_oe <= 1'b0;
		end
		else
		begin
			if (ext_wr)
			begin
				mem_wdata <= cpu_wdata;
				check_out <= e.wcheck;
			end
			check_oe <= ext_wr && en_s2_q;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cpu_rdata <= '0;
			cpu_rvalid <= 1'b0;
		end
		else
		begin
			cpu_rvalid <= ext_rd;
			if (ext_rd)
				cpu_rdata <= prot_rd ? e.corrected : md_s2_q;
		end
	end

	// unprotected reads raise nothing
	assign sgl_ev = prot_rd && e.single_err;
	assign dbl_ev = prot_rd && e.double_err;

	// ------------------------------------------------------------
	// apb register file
	// ------------------------------------------------------------
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// error flag and counter are sticky; a hardware event beats a write, except a single event on a full count, where the written count loads
	always_ff @(posedge clk)
	begin
		if (reset)
			ccs_q <= ccs_reset;
		else
		begin
			if (wr_acc && paddr == addr_ccs)
				ccs_q <= pwdata[7:0];
			if (dbl_ev)
				ccs_q[dbl_err_bit] <= 1'b1;
			if (sgl_ev && ccs_q[cnt_hi:0] != cnt_max)
				ccs_q[cnt_hi:0] <= ccs_q[cnt_hi:0] + 4'h1;
			else if (sgl_ev && wr_acc && paddr == addr_ccs)
				ccs_q[cnt_hi:0] <= pwdata[cnt_hi:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			prdata <= '0;
		else if (rd_acc && !penable)
		begin
			unique case (paddr)
				addr_ccs: prdata <= {24'h0, ccs_q};
				addr_irq_status: prdata <= {30'h0, status_q};
				addr_irq_enable: prdata <= {30'h0, enable_q};
				default: prdata <= '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	assign mode = ccs_q[irq_mode_hi:irq_mode_lo];

	// mode decides which error kinds may become interrupt events
	always_comb
	begin
		unique case (mode)
			irq_mode_off: gate = 2'h0;
			irq_mode_dbl: gate = 2'h2;
			irq_mode_sgl: gate = 2'h1;
			irq_mode_all: gate = 2'h3;
		endcase
	end

	assign ev = {dbl_ev, sgl_ev} & gate;
	assign clr = (wr_acc && paddr == addr_irq_clear) ?
		pwdata[ev_w-1:0] : '0;

	always_ff @(posedge clk)
	begin
		if (reset)
			status_q <= ev_reset;
		else
			status_q <= (status_q & ~clr) | ev;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			enable_q <= ev_reset;
		else if (wr_acc && paddr == addr_irq_enable)
			enable_q <= pwdata[ev_w-1:0];
	end

	assign irq = |(status_q & enable_q);
endmodule

//--- ecc_pkg.sv
// constants shared by the external memory correction block
package ecc_pkg;
	// register index 0x15 in window zero, byte address is four times it
	localparam logic [7:0] reg_idx_ccs = 8'h15;
	localparam logic [11:0] addr_ccs = {2'h0, reg_idx_ccs, 2'h0};
	localparam logic [11:0] addr_irq_status = 12'h100;
	localparam logic [11:0] addr_irq_clear = 12'h104;
	localparam logic [11:0] addr_irq_enable = 12'h108;
	localparam int irq_mode_hi = 6;
	localparam int irq_mode_lo = 5;
	localparam int dbl_err_bit = 4;
	localparam int cnt_hi = 3;
	localparam logic [7:0] ccs_reset = 8'h00;
	localparam logic [3:0] cnt_max = 4'hf;
	localparam int data_w = 16;
	localparam int chk_w = 5;
	// interrupt modes in the control bits
	localparam logic [1:0] irq_mode_off = 2'h0;
	localparam logic [1:0] irq_mode_dbl = 2'h1;
	localparam logic [1:0] irq_mode_sgl = 2'h2;
	localparam logic [1:0] irq_mode_all = 2'h3;
	// status bits
	localparam int ev_single = 0;
	localparam int ev_double = 1;
	localparam int ev_w = 2;
	localparam logic [1:0] ev_reset = 2'h0;
endpackage

//--- ecc_if.sv
// carries data and check bits between the engine and the codec
`timescale 1ns/1ns
interface ecc_if;
	import ecc_pkg::*;
	logic [data_w-1:0] wdata;
	logic [chk_w-1:0] wcheck;
	logic [data_w-1:0] rdata;
	logic [chk_w-1:0] rcheck;
	logic [data_w-1:0] corrected;
	logic single_err;
	logic double_err;
	modport engine
	(
		output wdata,
		input wcheck,
		output rdata,
		output rcheck,
		input corrected,
		input single_err,
		input double_err
	);
	modport codec
	(
		input wdata,
		output wcheck,
		input rdata,
		input rcheck,
		output corrected,
		output single_err,
		output double_err
	);
endinterface

//--- ecc_codec.sv
// hamming codec: 16 data bits and 5 check bits, single-bit correction
`timescale 1ns/1ns
module ecc_codec
	import ecc_pkg::*;
(
	ecc_if.codec c
);
	// ------------------------------------------------------------
	// code position of each data bit (skips powers of two)
	// ------------------------------------------------------------
	function automatic logic [4:0] pos_of(input int i);
		int p;
		int n;
		p = 0;
		n = -1;
		for (int k = 1; k < 32; k++)
		begin
			if (n < i && (k & (k - 1)) != 0)
			begin
				n = n + 1;
				p = k;
			end
		end
		return 5'(p);
	endfunction

	function automatic logic [4:0] syn_of(input logic [data_w-1:0] d);
		logic [4:0] s;
		s = 5'h00;
		for (int i = 0; i < data_w; i++)
		begin
			if (d[i])
				s = s ^ pos_of(i);
		end
		return s;
	endfunction

	logic [chk_w-1:0] syn;
	logic [4:0] last_pos;

	assign last_pos = 5'(data_w + chk_w);
	assign c.wcheck = syn_of(c.wdata);
	assign syn = syn_of(c.rdata) ^ c.rcheck;
	// five check bits cannot carry a full double detect for 16 data bits;
	// a syndrome past the last code position is the uncorrectable case
	assign c.single_err = syn != 5'h00 && syn <= last_pos;
	assign c.double_err = syn > last_pos;

	always_comb
	begin
		logic [4:0] p;
		p = 5'h00;
		c.corrected = c.rdata;
		for (int i = 0; i < data_w; i++)
		begin
			p = pos_of(i);
			if (c.single_err && p == syn)
				c.corrected[i] = !c.rdata[i];
		end
	end
endmodule

//--- ecc_engine_checker.sv
// port assertions for the correction engine
`timescale 1ns/1ns
module ecc_engine_checker
	import ecc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic ext_wr,
	input wire logic ext_rd,
	input wire logic [data_w-1:0] cpu_wdata,
	input wire logic cpu_rvalid,
	input wire logic [data_w-1:0] mem_wdata,
	input wire logic [chk_w-1:0] check_out,
	input wire logic check_oe,
	input wire logic correction_enable_input
);
	// enable history: the engine sees the pin through a synchroniser
	logic [2:0] en_q;
	always_ff @(posedge clk)
		en_q <= {en_q[1:0], correction_enable_input};
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_oe_protected: assert property (ext_wr && &{en_q, correction_enable_input}
		|=> check_oe) else $error("check port idle on write");
	a_oe_bare: assert property (ext_wr && ~|{en_q, correction_enable_input}
		|=> !check_oe) else $error("check port driven");
	a_oe_cause: assert property (check_oe |-> $past(ext_wr))
		else $error("check port driven without write");
	a_oe_single: assert property (check_oe && !ext_wr |=> !check_oe)
		else $error("check port held too long");
	a_wdata_copy: assert property (ext_wr |=> mem_wdata == $past(cpu_wdata))
		else $error("write data not passed");
	a_data_hold: assert property (!ext_wr |=> $stable(mem_wdata)
		&& $stable(check_out)) else $error("write side moved");
	a_read_answer: assert property (ext_rd |=> cpu_rvalid)
		else $error("read not answered");
	a_read_cause: assert property (cpu_rvalid |-> $past(ext_rd))
		else $error("stray read answer");
endmodule
bind ecc_engine ecc_engine_checker u_chk (.clk, .reset, .ext_wr, .ext_rd,
	.cpu_wdata, .cpu_rvalid, .mem_wdata, .check_out, .check_oe,
	.correction_enable_input);

//--- ecc_mem_model.sv
// far-side memory: one word of data and check bits
`timescale 1ns/1ns
module ecc_mem_model
	import ecc_pkg::*;
(
	input wire logic clk,
	input wire logic ext_wr,
	input wire logic [data_w-1:0] mem_wdata,
	input wire logic [chk_w-1:0] check_out,
	input wire logic check_oe,
	input wire logic [data_w+chk_w-1:0] flip,
	output logic [data_w-1:0] mem_rdata,
	output logic [chk_w-1:0] check_in
);
	logic wr_q = 1'b0;
	logic [data_w+chk_w-1:0] cell_q = '0;
	always_ff @(posedge clk)
	begin
		wr_q <= ext_wr;
		// undriven check lines leave the inverse, never a stale copy
		if (wr_q)
			cell_q <= {check_oe ? check_out : ~cell_q[data_w+:chk_w],
				mem_wdata};
	end
	// flip stands for upsets in the stored word
	assign {check_in, mem_rdata} = cell_q ^ flip;
endmodule

//--- testbench.sv
// self-checking bench for the correction engine
`timescale 1ns/1ns
module testbench;
	import ecc_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, check_oe, cpu_rvalid, irq;
	logic ext_wr = 1'b0, ext_rd = 1'b0, en = 1'b0;
	logic [data_w-1:0] cpu_wdata = '0, cpu_rdata, mem_wdata, mem_rdata, got;
	logic [chk_w-1:0] check_out, check_in;
	logic [data_w+chk_w-1:0] flip = '0;
	int failures = 0, checks_done = 0;
	always #5 clk = ~clk;
	ecc_engine u_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .ext_wr, .ext_rd, .cpu_wdata,
		.cpu_rdata, .cpu_rvalid, .mem_rdata, .mem_wdata, .check_in,
		.check_out, .check_oe, .correction_enable_input(en), .irq);
	ecc_mem_model u_mem (.clk, .ext_wr, .mem_wdata, .check_out, .check_oe,
		.flip, .mem_rdata, .check_in);
	task automatic complete_run;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		tick(1);
		penable <= 1'b1;
		n = 0;
		do
		begin
			tick(1);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			failures++;
			complete_run();
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		tick(1);
	endtask
	// enable is set well before the strobe and kept through the access
	task automatic mem_wr(input logic e, input logic [data_w-1:0] d);
		en <= e;
		cpu_wdata <= d;
		tick(4);
		ext_wr <= 1'b1;
		tick(1);
		ext_wr <= 1'b0;
		tick(3);
	endtask
	task automatic mem_rd(input logic [data_w+chk_w-1:0] f);
		int n;
		flip <= f;
		tick(3);
		ext_rd <= 1'b1;
		tick(1);
		ext_rd <= 1'b0;
		n = 0;
		do
		begin
			tick(1);
			n++;
		end
		while (cpu_rvalid !== 1'b1 && n < 8);
		if (cpu_rvalid !== 1'b1)
		begin
			failures++;
			complete_run();
		end
		got = cpu_rdata;
	endtask
	task automatic t_regs;
		apb(1'b0, addr_ccs, '0);
		check(rd, 32'(ccs_reset));
		apb(1'b0, addr_irq_status, '0);
		check(rd, 32'(ev_reset));
		apb(1'b0, 12'h200, '0);
		check(rd, '0);
		check(32'(pslverr), 32'h0);
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, addr_ccs, 32'(m) << irq_mode_lo);
			apb(1'b0, addr_ccs, '0);
			check(rd, 32'(m) << 5);
		end
		apb(1'b1, addr_irq_enable, 32'h3);
		$display("register test done");
	endtask
	// every single upset position, past the point where the count is full
	task automatic t_single;
		mem_wr(1'b1, 16'ha5c3);
		for (int i = 0; i < 21; i++)
		begin
			mem_rd(21'h1 << i);
			check(32'(got), 32'ha5c3);
			if (i == 0)
			begin
				apb(1'b0, addr_ccs, '0);
				check(rd, 32'h61);
				check(32'(irq), 32'h1);
			end
		end
		apb(1'b0, addr_ccs, '0);
		check(rd, 32'h6f);
		apb(1'b1, addr_irq_clear, 32'h1);
		check(32'(irq), 32'h0);
		$display("single test done");
	endtask
	task automatic t_double;
		// single-only mode: the flag still sets, no double event
		apb(1'b1, addr_ccs, 32'h4f);
		mem_rd(21'h28000);
		apb(1'b0, addr_ccs, '0);
		check(rd, 32'h5f);
		apb(1'b0, addr_irq_status, '0);
		check(rd, 32'h0);
		apb(1'b1, addr_ccs, 32'h2f);
		mem_rd(21'h28000);
		apb(1'b0, addr_ccs, '0);
		check(rd, 32'h3f);
		apb(1'b0, addr_irq_status, '0);
		check(rd, 32'h2);
		apb(1'b1, addr_irq_enable, '0);
		check(32'(irq), 32'h0);
		apb(1'b1, addr_irq_enable, 32'h3);
		check(32'(irq), 32'h1);
		apb(1'b1, addr_irq_clear, 32'h3);
		check(32'(irq), 32'h0);
		$display("double test done");
	endtask
	task automatic t_unprot;
		apb(1'b1, addr_ccs, 32'h60);
		mem_wr(1'b0, 16'h1234);
		mem_rd(21'h1);
		check(32'(got), 32'h1235);
		apb(1'b0, addr_ccs, '0);
		check(rd, 32'h60);
		apb(1'b0, addr_irq_status, '0);
		check(rd, '0);
		$display("unprotected test done");
	endtask
	initial
	begin
		tick(4);
		reset <= 1'b0;
		tick(1);
		t_regs();
		t_single();
		t_double();
		t_unprot();
		complete_run();
	end
endmodule
